// *** core/boot_rom_memory_port_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module boot_rom_memory_port_decode
   import map_decode_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_srst,
   input  wire cpu_bus_t          i_bus,
   output var mem_sel_t           o_mem,
   output logic [NPORTS-1:0]      o_port_rd,
   output logic [NPORTS-1:0]      o_port_wr,
   output logic [NPORTS-1:0]      o_port_hit,
   output logic [1:0]             o_map_mode,
   output logic                   o_rom_off
);

   map_mode_t  mode_r;
   logic       rom_off_r;
   logic [1:0] page_r;
   logic       io_wr_d_r;
   logic       wr_edge;
   logic       rom_mapped;
   logic       in_rom;
   logic       in_low;
   logic       upper;
   logic [PORT_W-1:0] port;

   assign port = i_bus.addr[PORT_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Port decode.
   port_decode u_ports (
      .i_port     (port),
      .i_io_rd    (i_bus.io_rd),
      .i_io_wr    (i_bus.io_wr),
      .o_rd_sel   (o_port_rd),
      .o_wr_sel   (o_port_wr),
      .o_addr_hit (o_port_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Latches update once per write cycle, on the strobe's leading edge, so a
   // long strobe cannot retrigger.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         io_wr_d_r <= 1'b0;
      end else begin
         io_wr_d_r <= i_bus.io_wr;
      end
   end

   assign wr_edge = i_bus.io_wr & ~io_wr_d_r;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         mode_r <= RESET_MODE;
         page_r <= RESET_PAGE;
      end else if (wr_edge && port == PORT_MAP_SEL) begin
         mode_r <= map_mode_t'(i_bus.wdata[MODE_LSB+1:MODE_LSB]);
         page_r <= i_bus.wdata[PAGE_HSB:PAGE_LSB];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rom_off_r <= RESET_ROM_OFF;
      end else if (wr_edge && port == PORT_ROM_OFF) begin
         rom_off_r <= i_bus.wdata[ROM_OFF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory steering. Selects are combinational so they track the address
   // within the same bus cycle.
   assign rom_mapped = ~rom_off_r && (mode_r == MAP_MODE0 || mode_r == MAP_MODE1);
   assign in_rom     = i_bus.addr <= ROM_TOP;
   assign in_low     = i_bus.addr <= LOWRAM_TOP;
   assign upper      = i_bus.addr[HALF_BIT];

   always_comb begin
      o_mem          = '0;
      o_mem.ram_page = page_r;
      o_mem.ram_a15  = upper;
      if (rom_mapped && in_rom) begin
         o_mem.rom_sel = i_bus.mem_rd;
         o_mem.ram_wr  = i_bus.mem_wr && mode_r == MAP_MODE1;
      end else if (rom_mapped && in_low && mode_r == MAP_MODE0) begin
         o_mem.ram_rd = i_bus.mem_rd;
      end else begin
         o_mem.ram_rd = i_bus.mem_rd;
         o_mem.ram_wr = i_bus.mem_wr;
      end
   end

   assign o_map_mode = mode_r;
   assign o_rom_off  = rom_off_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   // A strobe held across many clocks must not count as a second write, so
   // the latch load checks key off the leading edge wr_edge, not the strobe level.
   logic       map_hit;
   logic       off_hit;
   logic [1:0] wr_mode;
   logic [1:0] wr_page;
   logic       wr_off;

   assign map_hit = wr_edge && port == PORT_MAP_SEL;
   assign off_hit = wr_edge && port == PORT_ROM_OFF;
   assign wr_mode = i_bus.wdata[MODE_LSB+1:MODE_LSB];
   assign wr_page = i_bus.wdata[PAGE_HSB:PAGE_LSB];
   assign wr_off  = i_bus.wdata[ROM_OFF_BIT];

   sequence s_off_write;
      off_hit && wr_off;
   endsequence

   sequence s_on_write;
      off_hit && !wr_off;
   endsequence

   sequence s_map_write;
      map_hit;
   endsequence

   sequence s_unmap_mode;
      map_hit && (wr_mode == MAP_MODE2 || wr_mode == MAP_MODE3);
   endsequence

   sequence s_held_write;
      !i_srst && i_bus.io_wr && io_wr_d_r;
   endsequence

   rom_reset_a: assert property (@(posedge i_mclk)
      $fell(i_srst)
      |-> mode_r == MAP_MODE0 && !rom_off_r)
      else $error("reset did not restore mode 0 with rom");

   reset_clear_a: assert property (@(posedge i_mclk)
      i_srst
      |=> mode_r == RESET_MODE && rom_off_r == RESET_ROM_OFF && page_r == RESET_PAGE)
      else $error("reset did not clear the latches");

   rom_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      rom_mapped && in_rom && i_bus.mem_rd
      |-> o_mem.rom_sel && !o_mem.ram_rd)
      else $error("rom not selected in its window");

   rom_window_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_mem.rom_sel
      |-> rom_mapped && in_rom && i_bus.mem_rd)
      else $error("rom selected outside its window");

   rom_unmap_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      s_off_write
      |=> !rom_mapped)
      else $error("rom still mapped after disable write");

   mode_unmap_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      s_unmap_mode
      |=> !rom_mapped)
      else $error("rom still mapped after mode 2 or 3");

   mode23_rom_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      mode_r == MAP_MODE2 || mode_r == MAP_MODE3
      |-> !o_mem.rom_sel)
      else $error("rom selected in mode 2 or 3");

   off_load_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      off_hit
      |=> o_rom_off == $past(wr_off))
      else $error("rom disable latch not loaded");

   unmap_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_srst && rom_off_r && !off_hit
      |=> !rom_mapped)
      else $error("rom came back without a write");

   rom_remap_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      s_on_write
      |=> !rom_off_r)
      else $error("rom disable not cleared by write");

   mode1_write_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      mode_r == MAP_MODE1 && in_low && i_bus.mem_wr
      |-> o_mem.ram_wr)
      else $error("low ram not writable in mode 1");

   mode1_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      mode_r == MAP_MODE1 && rom_mapped && in_rom && i_bus.mem_rd
      |-> o_mem.rom_sel && !o_mem.ram_rd)
      else $error("mode 1 read not from rom");

   mode_load_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      s_map_write
      |=> o_map_mode == $past(wr_mode))
      else $error("map mode not loaded");

   unmapped_ram_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !rom_mapped
      |-> !o_mem.rom_sel && o_mem.ram_rd == i_bus.mem_rd && o_mem.ram_wr == i_bus.mem_wr)
      else $error("ram not selected with rom unmapped");

   low_readonly_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      mode_r == MAP_MODE0 && rom_mapped && in_low
      |-> !o_mem.ram_wr)
      else $error("low ram written in mode 0");

   sel_excl_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_mem.rom_sel
      |-> !o_mem.ram_rd)
      else $error("rom and ram read together");

   ram_idle_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_bus.mem_rd && !i_bus.mem_wr
      |-> !o_mem.rom_sel && !o_mem.ram_rd && !o_mem.ram_wr)
      else $error("memory select without strobe");

   page_load_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      s_map_write
      |=> o_mem.ram_page == $past(wr_page))
      else $error("ram page not loaded");

   page_out_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_srst && !map_hit
      |=> $stable(o_mem.ram_page))
      else $error("ram page changed without write");

   upper_ram_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      upper
      |-> !o_mem.rom_sel && o_mem.ram_rd == i_bus.mem_rd && o_mem.ram_wr == i_bus.mem_wr)
      else $error("upper half not paged ram");

   latch_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_srst && !wr_edge
      |=> $stable(mode_r) && $stable(rom_off_r))
      else $error("latch changed without write");

   held_write_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      s_held_write
      |=> $stable(mode_r) && $stable(rom_off_r) && $stable(page_r))
      else $error("held strobe wrote again");

   off_keep_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      off_hit
      |=> $stable(mode_r) && $stable(page_r))
      else $error("rom port write disturbed map");

   map_keep_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      map_hit
      |=> $stable(rom_off_r))
      else $error("map port write disturbed rom latch");

   other_port_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      wr_edge && !map_hit && !off_hit
      |=> $stable(mode_r) && $stable(rom_off_r) && $stable(page_r))
      else $error("other port write changed a latch");

   hit_onehot_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      $onehot(o_port_hit)
      && o_port_hit[port])
      else $error("port decode not one hot");

   port_rd_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_bus.io_rd
      |-> o_port_rd == '0)
      else $error("read select without strobe");

   rd_select_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      i_bus.io_rd
      |-> o_port_rd[port] && $onehot(o_port_rd))
      else $error("read select wrong");

   port_wr_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      i_bus.io_wr
      |-> o_port_wr[port] && $onehot(o_port_wr))
      else $error("write select wrong");

   wr_idle_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_bus.io_wr
      |-> o_port_wr == '0)
      else $error("write select without strobe");

   port_qual_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_port_rd
      == (o_port_hit & {NPORTS{i_bus.io_rd}}))
      else $error("read select not qualified");

   wr_qual_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_port_wr
      == (o_port_hit & {NPORTS{i_bus.io_wr}}))
      else $error("write select not qualified");

endmodule
`default_nettype wire

// *** core/map_decode_pkg.sv ***
package map_decode_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int PORT_W = 8;
   localparam int NPORTS = 256;

   localparam logic [PORT_W-1:0] PORT_ROM_OFF = 8'h9C;
   localparam logic [PORT_W-1:0] PORT_MAP_SEL = 8'h84;
   localparam int                ROM_OFF_BIT  = 0;
   localparam int                MODE_LSB     = 0;
   localparam int                PAGE_LSB     = 4;
   localparam int                PAGE_HSB     = 5;

   localparam logic [ADDR_W-1:0] ROM_TOP    = 16'h0FFF;
   localparam logic [ADDR_W-1:0] LOWRAM_TOP = 16'h37FF;
   localparam logic [ADDR_W-1:0] HALF_BASE  = 16'h8000;
   localparam int                HALF_BIT   = 15;

   typedef enum logic [1:0] {
      MAP_MODE0,
      MAP_MODE1,
      MAP_MODE2,
      MAP_MODE3
   } map_mode_t;

   localparam map_mode_t RESET_MODE    = MAP_MODE0;
   localparam logic      RESET_ROM_OFF = 1'b0;
   localparam logic [1:0] RESET_PAGE   = 2'h0;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              mem_rd;
      logic              mem_wr;
      logic              io_rd;
      logic              io_wr;
   } cpu_bus_t;

   typedef struct packed {
      logic       rom_sel;
      logic       ram_rd;
      logic       ram_wr;
      logic [1:0] ram_page;
      logic       ram_a15;
   } mem_sel_t;

endpackage

// *** core/port_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module port_decode
   import map_decode_pkg::*;
(
   input  wire logic [PORT_W-1:0] i_port,
   input  wire logic              i_io_rd,
   input  wire logic              i_io_wr,
   output logic [NPORTS-1:0]      o_rd_sel,
   output logic [NPORTS-1:0]      o_wr_sel,
   output logic [NPORTS-1:0]      o_addr_hit
);

   ////////////////////////////////////////////////////////////////////////////
   // One-hot decode per port; strobe qualification keeps the address-only
   // stage from reaching a port outside a cycle.
   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      assign o_addr_hit[p] = (i_port == PORT_W'(p));
      assign o_rd_sel[p]   = o_addr_hit[p] & i_io_rd;
      assign o_wr_sel[p]   = o_addr_hit[p] & i_io_wr;
   end

endmodule
`default_nettype wire

// *** test/cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_model
   import map_decode_pkg::*;
(
   input  wire logic i_mclk,
   output var cpu_bus_t o_bus
);
   // Strobes start idle so that nothing is written while reset is held.
   initial o_bus = '0;
   task automatic drive(input cpu_bus_t b);
      @(posedge i_mclk);
      o_bus <= b;
      #1;
   endtask
   task automatic io_write(input logic [7:0] port, input logic [7:0] data);
      cpu_bus_t b;
      b = '0;
      b.addr = {8'hA5, port};
      b.wdata = data;
      b.io_wr = 1'b1;
      drive(b);
      // A released bus shows the inverse of its last address and data, never a stale copy.
      b.io_wr = 1'b0;
      b.addr = ~b.addr;
      b.wdata = ~data;
      drive(b);
      drive(b);
   endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: output mismatch", $time); end end
module testbench;
   import map_decode_pkg::*;
   logic              i_mclk = 1'b0;
   logic              i_srst = 1'b1;
   cpu_bus_t          bus;
   mem_sel_t          mem;
   logic [NPORTS-1:0] prd, pwr, phit;
   logic [1:0]        mode;
   logic              roff;
   int                err_total = 0;
   int                compares = 0;
   logic [31:0]       seed = 32'hE5C3ECD3;
   logic [15:0]       corner [4] = '{16'h0FFF, 16'h1000, 16'h37FF, 16'h3800};
   always #12.5 i_mclk = ~i_mclk;
   cpu_model CPU (.i_mclk(i_mclk), .o_bus(bus));
   boot_rom_memory_port_decode DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_bus(bus),
      .o_mem(mem), .o_port_rd(prd), .o_port_wr(pwr), .o_port_hit(phit),
      .o_map_mode(mode), .o_rom_off(roff));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic mem_sel_t exp_mem(input logic [1:0] m, input logic off,
                                        input logic [1:0] pg, input cpu_bus_t b);
      mem_sel_t e;
      logic     on;
      on = !off && (m < 2'h2);
      e.rom_sel = on && (b.addr <= ROM_TOP) && b.mem_rd;
      e.ram_rd = b.mem_rd && !(on && (b.addr <= ROM_TOP));
      e.ram_wr = b.mem_wr && !(on && (m == 2'h0) && (b.addr <= LOWRAM_TOP));
      e.ram_page = pg;
      e.ram_a15 = b.addr[15];
      return e;
   endfunction
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic mem_check(input logic [1:0] m, input logic off, input logic [1:0] pg);
      cpu_bus_t b;
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         b = '0;
         b.addr = (i < 4) ? corner[i] : seed[15:0];
         // Corners alternate read and write, so each window's last address is read and the next one written.
         b.mem_rd = (i < 4) ? !i[0] : seed[16];
         b.mem_wr = !b.mem_rd;
         CPU.drive(b);
         `CHK(mem, exp_mem(m, off, pg, b))
         `CHK(mode, m)
         `CHK(roff, off)
      end
      $display("memory test done, mode %0d", m);
   endtask
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_total++;
      stop_test;
   end
   initial begin
      cpu_bus_t          b;
      logic [NPORTS-1:0] oh;
      repeat (2) @(posedge i_mclk);
      i_srst <= 1'b0;
      mem_check(2'h0, 1'b0, 2'h0);
      for (int i = 0; i < 32; i++) begin
         seed = lfsr(seed);
         b = '0;
         b.addr = seed[15:0];
         // Control ports are skipped here so random writes leave the map alone.
         if (b.addr[7:0] == PORT_MAP_SEL || b.addr[7:0] == PORT_ROM_OFF) b.addr[0] = 1'b1;
         b.io_rd = seed[16];
         b.io_wr = seed[17] && !seed[16];
         oh = '0;
         oh[b.addr[7:0]] = 1'b1;
         CPU.drive(b);
         `CHK(phit, oh)
         `CHK(prd, b.io_rd ? oh : '0)
         `CHK(pwr, b.io_wr ? oh : '0)
      end
      $display("port test done");
      CPU.io_write(PORT_MAP_SEL, 8'h01);
      mem_check(2'h1, 1'b0, 2'h0);
      CPU.io_write(PORT_ROM_OFF, 8'h01);
      mem_check(2'h1, 1'b1, 2'h0);
      CPU.io_write(PORT_ROM_OFF, 8'h00);
      mem_check(2'h1, 1'b0, 2'h0);
      CPU.io_write(PORT_MAP_SEL, 8'h32);
      mem_check(2'h2, 1'b0, 2'h3);
      CPU.io_write(PORT_MAP_SEL, 8'h13);
      seed = lfsr(seed);
      CPU.io_write(8'h85, seed[7:0]);
      mem_check(2'h3, 1'b0, 2'h1);
      // The ROM latch is set first so the reset below has something to clear.
      CPU.io_write(PORT_ROM_OFF, 8'h01);
      @(posedge i_mclk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_srst <= 1'b0;
      mem_check(2'h0, 1'b0, 2'h0);
      stop_test;
   end
endmodule
`default_nettype wire
